// *** logic/ulfts_pkg.sv ***
// package: register map, field positions and trigger tables for the line/format control block
package ulfts_pkg;
	// register byte offsets (aligned words)
	localparam logic [7:0] OFS_DATA_LOW = 8'h00;
	localparam logic [7:0] OFS_DATA_HIGH = 8'h04;
	localparam logic [7:0] OFS_FIFO_SETUP = 8'h08;
	localparam logic [7:0] OFS_LINE_FORMAT = 8'h0C;
	localparam logic [7:0] OFS_MODEM_LINE = 8'h10;
	localparam logic [7:0] OFS_FEATURE_TUNING = 8'h14;
	localparam logic [7:0] OFS_ENH_FEATURE = 8'h18;
	localparam logic [7:0] OFS_RX_PROG_TRIG = 8'h1C;
	localparam logic [7:0] OFS_TX_PROG_TRIG = 8'h20;
	localparam logic [7:0] OFS_FIFO_LEVEL = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	// field positions
	localparam int FS_ENABLE = 0;
	localparam int FS_TX_LO = 4;
	localparam int FS_RX_LO = 6;
	localparam int LF_STOP = 2;
	localparam int LF_PAR_EN = 3;
	localparam int LF_EVEN = 4;
	localparam int LF_FORCE = 5;
	localparam int LF_BREAK = 6;
	localparam int LF_DIV_SEL = 7;
	localparam int ML_DTR = 0;
	localparam int ML_RTS = 1;
	localparam int ML_FLOW_SEL = 2;
	localparam int FT_TABLE_LO = 6;
	localparam int EF_ENHANCED = 4;
	localparam int EF_AUTO_OUT = 6;
	// reset values
	localparam logic [7:0] RST_LINE_FORMAT = 8'h00;
	localparam logic [7:0] RST_MODEM_LINE = 8'h00;
	localparam logic [7:0] RST_FEATURE = 8'h00;
	localparam logic [7:0] RST_ENH = 8'h00;
	localparam logic [7:0] RST_PROG_TRIG = 8'h01;
	localparam logic [7:0] RST_DIVISOR = 8'h01;
	localparam logic [1:0] RST_TRIG_CODE = 2'h0;
	// stop length in half bit times
	localparam logic [2:0] STOP_HALVES_ONE = 3'h2;
	localparam logic [2:0] STOP_HALVES_ONE_HALF = 3'h3;
	localparam logic [2:0] STOP_HALVES_TWO = 3'h4;

	typedef enum logic [3:0]
	{
		ULFTS_TAB_A = 4'b0001,
		ULFTS_TAB_B = 4'b0010,
		ULFTS_TAB_C = 4'b0100,
		ULFTS_TAB_D = 4'b1000
	} ulfts_table_e;

	// framing word handed to shift registers
	typedef struct packed
	{
		logic [3:0] data_bits;
		logic [2:0] stop_halves;
		logic parity_en;
		logic parity_fixed;
		logic parity_value;
		logic parity_even;
		logic break_hold;
	} ulfts_frame_s;

	// levels in characters, 0..64
	typedef logic [6:0] ulfts_level_t;

	typedef struct packed
	{
		ulfts_level_t rx_level;
		ulfts_level_t tx_level;
	} ulfts_fifo_s;
endpackage : ulfts_pkg

// *** logic/ulfts_top.sv ***
// top: apb register file, framing, trigger thresholds and modem output drive
// How it works
// - receive threshold picked by fifo_setup bits 7:6; code 00 means one character in table A, eight in B and C.
// - both directions use one table; feature_tuning bits 7:6 decide it.
// - feature_tuning bits 7:6 pick table A, B, C or programmable D.
// - table A receive 1,4,8,14; transmit always 1.
// - tables B and C give their listed receive and transmit thresholds.
// - line_format bits 1:0 set word length five to eight bits.
// - bit 2 gives one, one and a half, or two stop bits.
// - bit 3 enables parity generation and checking.
// - bit 4 chooses odd when clear, even when set.
// - bit 5 forces parity to one or zero by bit 4.
// - bit 6 holds serial output low as break until cleared.
// - bit 7 redirects data addresses to the baud divisor latches.
// - modem bit 0 set drives the active-low dtr pin low.
// - modem bit 1 set drives the active-low rts pin low.
// - dtr joins auto flow control when auto enable and select one.
// - rts joins auto flow control when auto enable and select zero.
// - fifo_setup bits 5:4 pick transmit threshold; ready when level below it.
// - fifo_setup fields change only when enable bit written one too.
// - trigger fields writable only after enhanced enable bit 4 set.
// - modem bit 2 picks rts/cts pair at zero, dtr/dsr at one.
`timescale 1ns/1ns
module ulfts_top
	import ulfts_pkg::*;
(
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// fifo levels from the data path
	input wire ulfts_fifo_s fifo_levels,
	// remote side flow request, from the pins
	input wire logic flow_stop_async,
	// data path controls
	output ulfts_frame_s frame_cfg,
	output logic [15:0] baud_divisor,
	output logic data_reg_sel,
	output logic data_access,
	output logic fifo_enable,
	output logic rx_ready_level,
	output logic tx_ready_level,
	// serial and modem pins
	input wire logic tx_serial_in,
	output logic tx_serial_out,
	output logic dtr_n,
	output logic rts_n
);
	logic [7:0] line_format_r;
	logic [7:0] modem_line_control_r;
	logic [7:0] feature_tuning_r;
	logic [7:0] enhanced_feature_enable_r;
	logic [7:0] rx_prog_r;
	logic [7:0] tx_prog_r;
	logic [7:0] baud_divisor_low_r;
	logic [7:0] baud_divisor_high_r;
	logic fifo_on_r;
	logic [1:0] rx_code_r;
	logic [1:0] tx_code_r;
	ulfts_table_e table_r;
	ulfts_table_e table_nxt;
	ulfts_level_t rx_thr;
	ulfts_level_t tx_thr;
	logic [2:0] flow_sync_r;
	logic flow_stop_r;
	logic wr_acc;
	logic rd_acc;
	logic addr_ok;
	logic [7:0] rd_byte;
	logic auto_out;
	logic flow_assert_n;

	assign wr_acc = psel && penable && pwrite && clk_en;
	assign rd_acc = psel && penable && !pwrite && clk_en;

	always_comb
	begin
		case (paddr)
			OFS_DATA_LOW, OFS_DATA_HIGH, OFS_FIFO_SETUP, OFS_LINE_FORMAT,
			OFS_MODEM_LINE, OFS_FEATURE_TUNING, OFS_ENH_FEATURE,
			OFS_RX_PROG_TRIG, OFS_TX_PROG_TRIG, OFS_FIFO_LEVEL, OFS_STATUS:
				addr_ok = 1'b1;
			default:
				addr_ok = 1'b0;
		endcase
	end

	// table code from feature_tuning bits 7:6
	always_comb
	begin
		case (feature_tuning_r[FT_TABLE_LO +: 2])
			2'h0: table_nxt = ULFTS_TAB_A;
			2'h1: table_nxt = ULFTS_TAB_B;
			2'h2: table_nxt = ULFTS_TAB_C;
			default: table_nxt = ULFTS_TAB_D;
		endcase
	end

	// line format register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			line_format_r <= RST_LINE_FORMAT;
		else if (wr_acc && paddr == OFS_LINE_FORMAT)
			line_format_r <= pwdata[7:0];
	end

	// modem, feature and enhanced registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			modem_line_control_r <= RST_MODEM_LINE;
			feature_tuning_r <= RST_FEATURE;
			enhanced_feature_enable_r <= RST_ENH;
			rx_prog_r <= RST_PROG_TRIG;
			tx_prog_r <= RST_PROG_TRIG;
		end
		else if (wr_acc)
		begin
			case (paddr)
				OFS_MODEM_LINE: modem_line_control_r <= pwdata[7:0];
				OFS_FEATURE_TUNING: feature_tuning_r <= pwdata[7:0];
				OFS_ENH_FEATURE: enhanced_feature_enable_r <= pwdata[7:0];
				OFS_RX_PROG_TRIG: rx_prog_r <= pwdata[7:0];
				OFS_TX_PROG_TRIG: tx_prog_r <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// divisor latches reached only through redirected data addresses
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			baud_divisor_low_r <= RST_DIVISOR;
			baud_divisor_high_r <= 8'h00;
		end
		else if (wr_acc && line_format_r[LF_DIV_SEL])
		begin
			if (paddr == OFS_DATA_LOW)
				baud_divisor_low_r <= pwdata[7:0];
			else if (paddr == OFS_DATA_HIGH)
				baud_divisor_high_r <= pwdata[7:0];
		end
	end

	// fifo_setup is write-only; fields latch only with enable bit set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fifo_on_r <= 1'b0;
			rx_code_r <= RST_TRIG_CODE;
			tx_code_r <= RST_TRIG_CODE;
		end
		else if (wr_acc && paddr == OFS_FIFO_SETUP)
		begin
			fifo_on_r <= pwdata[FS_ENABLE];
			// a write with enable clear programs nothing else
			if (pwdata[FS_ENABLE] && enhanced_feature_enable_r[EF_ENHANCED])
			begin
				rx_code_r <= pwdata[FS_RX_LO +: 2];
				tx_code_r <= pwdata[FS_TX_LO +: 2];
			end
		end
	end

	// one table for both sides; follows feature_tuning bits 7:6 on each enabled edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			table_r <= ULFTS_TAB_A;
		else if (clk_en)
			table_r <= table_nxt;
	end

	ulfts_trigger_table u_table
	(
		.table_sel(table_r),
		.rx_code(rx_code_r),
		.tx_code(tx_code_r),
		.rx_prog(rx_prog_r),
		.tx_prog(tx_prog_r),
		.rx_thr(rx_thr),
		.tx_thr(tx_thr)
	);

	// thresholds compared against live levels; fifo data never touched
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_ready_level <= 1'b0;
			tx_ready_level <= 1'b0;
		end
		else if (clk_en)
		begin
			rx_ready_level <= fifo_on_r && (fifo_levels.rx_level >= rx_thr);
			tx_ready_level <= fifo_on_r && (fifo_levels.tx_level < tx_thr);
		end
	end

	// framing decode for the shift registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			frame_cfg <= '0;
		else if (clk_en)
		begin
			frame_cfg.data_bits <= 4'h5 + {2'h0, line_format_r[1:0]};
			if (!line_format_r[LF_STOP])
				frame_cfg.stop_halves <= STOP_HALVES_ONE;
			else if (line_format_r[1:0] == 2'h0)
				frame_cfg.stop_halves <= STOP_HALVES_ONE_HALF;
			else
				frame_cfg.stop_halves <= STOP_HALVES_TWO;
			frame_cfg.parity_en <= line_format_r[LF_PAR_EN];
			frame_cfg.parity_even <= line_format_r[LF_EVEN];
			frame_cfg.parity_fixed <= line_format_r[LF_PAR_EN] && line_format_r[LF_FORCE];
			frame_cfg.parity_value <= !line_format_r[LF_EVEN];
			frame_cfg.break_hold <= line_format_r[LF_BREAK];
		end
	end

	// break overrides the transmitter bit; held low until cleared
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_serial_out <= 1'b1;
		else if (clk_en)
			tx_serial_out <= line_format_r[LF_BREAK] ? 1'b0 : tx_serial_in;
	end

	// data register steering
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			baud_divisor <= {8'h00, RST_DIVISOR};
			data_reg_sel <= 1'b0;
			data_access <= 1'b0;
			fifo_enable <= 1'b0;
		end
		else if (clk_en)
		begin
			baud_divisor <= {baud_divisor_high_r, baud_divisor_low_r};
			data_reg_sel <= line_format_r[LF_DIV_SEL];
			// pulse to data path only when data registers are selected
			data_access <= psel && penable && !line_format_r[LF_DIV_SEL] &&
				(paddr == OFS_DATA_LOW || paddr == OFS_DATA_HIGH);
			fifo_enable <= fifo_on_r;
		end
	end

	// flow stop from pins: three stages, change taken when last two agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flow_sync_r <= 3'h0;
			flow_stop_r <= 1'b0;
		end
		else if (clk_en)
		begin
			flow_sync_r <= {flow_sync_r[1:0], flow_stop_async};
			if (flow_sync_r[2] == flow_sync_r[1])
				flow_stop_r <= flow_sync_r[2];
		end
	end

	assign auto_out = enhanced_feature_enable_r[EF_AUTO_OUT];
	// auto flow: pin released high when remote asks to stop or manual bit clear
	assign flow_assert_n = flow_stop_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dtr_n <= 1'b1;
			rts_n <= 1'b1;
		end
		else if (clk_en)
		begin
			if (auto_out && modem_line_control_r[ML_FLOW_SEL])
				dtr_n <= !modem_line_control_r[ML_DTR] || flow_assert_n;
			else
				dtr_n <= !modem_line_control_r[ML_DTR];
			if (auto_out && !modem_line_control_r[ML_FLOW_SEL])
				rts_n <= !modem_line_control_r[ML_RTS] || flow_assert_n;
			else
				rts_n <= !modem_line_control_r[ML_RTS];
		end
	end

	always_comb
	begin
		case (paddr)
			OFS_DATA_LOW: rd_byte = line_format_r[LF_DIV_SEL] ? baud_divisor_low_r : 8'h00;
			OFS_DATA_HIGH: rd_byte = line_format_r[LF_DIV_SEL] ? baud_divisor_high_r : 8'h00;
			OFS_LINE_FORMAT: rd_byte = line_format_r;
			OFS_MODEM_LINE: rd_byte = modem_line_control_r;
			OFS_FEATURE_TUNING: rd_byte = feature_tuning_r;
			OFS_ENH_FEATURE: rd_byte = enhanced_feature_enable_r;
			OFS_RX_PROG_TRIG: rd_byte = rx_prog_r;
			OFS_TX_PROG_TRIG: rd_byte = tx_prog_r;
			OFS_FIFO_LEVEL: rd_byte = {1'b0, rx_thr};
			OFS_STATUS: rd_byte = {fifo_on_r, tx_ready_level, rx_ready_level, 1'b0, table_r};
			default: rd_byte = 8'h00;
		endcase
	end

	// no wait state: ready and read data set on the setup cycle's following edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (psel && !penable && !pwrite)
				prdata <= {24'h00_0000, rd_byte};
			else if (rd_acc && pready)
				prdata <= 32'h0000_0000;
		end
	end
endmodule : ulfts_top

// *** logic/ulfts_trigger_table.sv ***
// trigger-table lookup: table code and field codes to thresholds
`timescale 1ns/1ns
module ulfts_trigger_table
	import ulfts_pkg::*;
(
	// selection
	input wire ulfts_table_e table_sel,
	input wire logic [1:0] rx_code,
	input wire logic [1:0] tx_code,
	// programmable levels for table D
	input wire logic [7:0] rx_prog,
	input wire logic [7:0] tx_prog,
	// thresholds
	output ulfts_level_t rx_thr,
	output ulfts_level_t tx_thr
);
	always_comb
	begin
		rx_thr = 7'h01;
		tx_thr = 7'h01;
		case (table_sel)
			ULFTS_TAB_A:
			begin
				case (rx_code)
					2'h0: rx_thr = 7'h01;
					2'h1: rx_thr = 7'h04;
					2'h2: rx_thr = 7'h08;
					default: rx_thr = 7'h0E;
				endcase
				tx_thr = 7'h01;
			end
			ULFTS_TAB_B:
			begin
				case (rx_code)
					2'h0: rx_thr = 7'h08;
					2'h1: rx_thr = 7'h10;
					2'h2: rx_thr = 7'h18;
					default: rx_thr = 7'h1C;
				endcase
				case (tx_code)
					2'h0: tx_thr = 7'h10;
					2'h1: tx_thr = 7'h08;
					2'h2: tx_thr = 7'h18;
					default: tx_thr = 7'h1E;
				endcase
			end
			ULFTS_TAB_C:
			begin
				case (rx_code)
					2'h0: rx_thr = 7'h08;
					2'h1: rx_thr = 7'h10;
					2'h2: rx_thr = 7'h38;
					default: rx_thr = 7'h3C;
				endcase
				case (tx_code)
					2'h0: tx_thr = 7'h08;
					2'h1: tx_thr = 7'h10;
					2'h2: tx_thr = 7'h20;
					default: tx_thr = 7'h38;
				endcase
			end
			ULFTS_TAB_D:
			begin
				// field codes ignored, levels come from software
				rx_thr = rx_prog[6:0];
				tx_thr = tx_prog[6:0];
			end
			default:
			begin
				rx_thr = 7'h01;
				tx_thr = 7'h01;
			end
		endcase
	end
endmodule : ulfts_trigger_table

// *** tb/ulfts_checker.sv ***
// checker: framing, break, divisor select and modem pin assertions
`timescale 1ns/1ns
module ulfts_checker
	import ulfts_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// outputs and pins
	input wire ulfts_frame_s frame_cfg,
	input wire logic data_reg_sel,
	input wire logic data_access,
	input wire logic tx_serial_in,
	input wire logic tx_serial_out,
	input wire logic flow_stop_async,
	input wire logic dtr_n,
	input wire logic rts_n
);
	logic wr;
	logic [7:0] lf_q;
	logic [7:0] ml_q;
	logic [7:0] ef_q;
	assign wr = psel && penable && pready && pwrite && clk_en;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lf_q <= 8'h00;
			ml_q <= 8'h00;
			ef_q <= 8'h00;
		end
		else
		begin
			if (wr && paddr == OFS_LINE_FORMAT)
				lf_q <= pwdata[7:0];
			if (wr && paddr == OFS_MODEM_LINE)
				ml_q <= pwdata[7:0];
			if (wr && paddr == OFS_ENH_FEATURE)
				ef_q <= pwdata[7:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// outputs lag register writes by one edge, so skip the edge right after one
	sequence s_calm;
		$past(presetn) && $past(clk_en) && !$past(wr);
	endsequence
	// remote stop held long enough to pass the pin synchroniser
	sequence s_stopped(bit sel);
		(flow_stop_async && ef_q[6] && ml_q[2] == sel) [*8];
	endsequence
	property p_apb;
		psel && !penable && clk_en |=> pready;
	endproperty
	// data path pulse follows an access at a data address with latches hidden
	property p_dacc;
		psel && penable && clk_en |=> data_access == (!$past(lf_q[7]) &&
			($past(paddr) == OFS_DATA_LOW || $past(paddr) == OFS_DATA_HIGH));
	endproperty
	property p_dacc_idle;
		clk_en && !(psel && penable) |=> !data_access;
	endproperty
	property p_word;
		s_calm |-> frame_cfg.data_bits == 4'(lf_q[1:0]) + 4'h5;
	endproperty
	property p_stop;
		s_calm |-> frame_cfg.stop_halves == (!lf_q[2] ? STOP_HALVES_ONE :
			(lf_q[1:0] == 2'h0 ? STOP_HALVES_ONE_HALF : STOP_HALVES_TWO));
	endproperty
	property p_par;
		s_calm |-> frame_cfg.parity_en == lf_q[3];
	endproperty
	property p_kind;
		s_calm ##0 lf_q[3] |-> frame_cfg.parity_even == lf_q[4] && frame_cfg.parity_fixed == lf_q[5];
	endproperty
	property p_force;
		s_calm ##0 (lf_q[3] && lf_q[5]) |-> frame_cfg.parity_value == !lf_q[4];
	endproperty
	property p_line;
		s_calm |-> tx_serial_out == (!lf_q[6] && $past(tx_serial_in)) &&
			frame_cfg.break_hold == lf_q[6];
	endproperty
	property p_dsel;
		s_calm |-> data_reg_sel == lf_q[7];
	endproperty
	property p_modem;
		s_calm ##0 !ef_q[6] |-> dtr_n == !ml_q[0] && rts_n == !ml_q[1];
	endproperty
	property p_auto_dtr;
		s_stopped(1'b1) |-> dtr_n;
	endproperty
	property p_auto_rts;
		s_stopped(1'b0) |-> rts_n;
	endproperty
	a_apb: assert property (p_apb) else $error("no ready after setup");
	a_word: assert property (p_word) else $error("word length wrong");
	a_stop: assert property (p_stop) else $error("stop length wrong");
	a_par: assert property (p_par) else $error("parity enable wrong");
	a_kind: assert property (p_kind) else $error("parity kind wrong");
	a_force: assert property (p_force) else $error("forced parity wrong");
	a_line: assert property (p_line) else $error("serial output wrong");
	a_dsel: assert property (p_dsel) else $error("divisor select wrong");
	a_dacc: assert property (p_dacc) else $error("data access pulse wrong");
	a_dacc_idle: assert property (p_dacc_idle) else $error("stray data access pulse");
	a_modem: assert property (p_modem) else $error("modem pins wrong");
	a_auto_dtr: assert property (p_auto_dtr) else $error("dtr not stopped");
	a_auto_rts: assert property (p_auto_rts) else $error("rts not stopped");
endmodule : ulfts_checker

bind ulfts_top ulfts_checker chk_i (.*);

// *** tb/ulfts_remote.sv ***
// remote modem model: raises flow stop after a chosen lag, watches the line
`timescale 1ns/1ns
module ulfts_remote
(
	// bench control
	input wire logic pclk,
	input wire logic stop_req,
	input wire logic [3:0] lag,
	// serial side pins
	input wire logic tx_line,
	output logic flow_stop_async,
	output logic [7:0] low_run
);
	logic [15:0] hist = 16'h0000;
	logic [7:0] run_r = 8'h00;
	// lag stands for a slow remote buffer
	always @(posedge pclk)
	begin
		hist <= {hist[14:0], stop_req};
		run_r <= tx_line ? 8'h00 : run_r + 8'h01;
	end
	assign flow_stop_async = hist[lag];
	assign low_run = run_r;
endmodule : ulfts_remote

// *** tb/ulfts_tb.sv ***
// testbench: apb stimulus, read scoreboard, threshold and pin checks
`timescale 1ns/1ns
module testbench;
	import ulfts_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	ulfts_fifo_s fifo_levels = '0;
	logic tx_serial_in = 1'b1;
	logic stop_req = 1'b0;
	logic [3:0] lag = 4'h0;
	logic flow_stop_async;
	ulfts_frame_s frame_cfg;
	logic [15:0] baud_divisor;
	logic fifo_enable;
	logic rx_ready_level;
	logic tx_ready_level;
	logic tx_serial_out;
	logic dtr_n;
	logic rts_n;
	logic [7:0] low_run;
	logic [32:0] exp_q [$];
	int err_total = 0;
	int compares = 0;
	logic [6:0] rxa [12] = '{7'h01, 7'h04, 7'h08, 7'h0E, 7'h08, 7'h10, 7'h18, 7'h1C,
		7'h08, 7'h10, 7'h38, 7'h3C};
	logic [6:0] txa [12] = '{7'h01, 7'h01, 7'h01, 7'h01, 7'h10, 7'h08, 7'h18, 7'h1E,
		7'h08, 7'h10, 7'h20, 7'h38};
	logic [6:0] p;
	logic [6:0] q;

	ulfts_top uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fifo_levels(fifo_levels),
		.flow_stop_async(flow_stop_async), .frame_cfg(frame_cfg), .baud_divisor(baud_divisor),
		.data_reg_sel(), .data_access(), .fifo_enable(fifo_enable),
		.rx_ready_level(rx_ready_level), .tx_ready_level(tx_ready_level),
		.tx_serial_in(tx_serial_in), .tx_serial_out(tx_serial_out), .dtr_n(dtr_n), .rts_n(rts_n));
	ulfts_remote remote (.pclk(pclk), .stop_req(stop_req), .lag(lag), .tx_line(tx_serial_out),
		.flow_stop_async(flow_stop_async), .low_run(low_run));

	always #20 pclk = ~pclk;
	always @(posedge pclk)
		tx_serial_in <= 1'($urandom);

	task chk(input logic [32:0] g, input logic [32:0] e);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task close_out;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	// hold the request until ready is seen, then one idle edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// only the watchdog ends a wait that never sees ready
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer

	task rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask : rd

	// levels at or one below the thresholds
	task lev(input logic [6:0] rt, input logic [6:0] tt);
		logic [6:0] r;
		logic [6:0] x;
		r = rt - 7'($urandom_range(1));
		x = tt - 7'($urandom_range(1));
		fifo_levels <= '{r, x};
		repeat (3) @(posedge pclk);
		chk(33'({rx_ready_level, tx_ready_level}), 33'({r >= rt, x < tt}));
	endtask : lev

	always @(posedge pclk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk({pslverr, prdata}, exp_q.pop_front());
	end

	initial
	begin
		#800000;
		err_total++;
		close_out();
	end

	initial
	begin
		void'($urandom(32'h9ADF));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_LINE_FORMAT, 33'h0);
		rd(OFS_MODEM_LINE, 33'h0);
		rd(OFS_FIFO_LEVEL, 33'h1);
		rd(8'h3C, 33'h100000000);
		chk(33'({dtr_n, rts_n}), 33'h3);
		$display("test reset done");
		xfer(1'b1, OFS_ENH_FEATURE, 32'h10);
		for (int i = 0; i < 12; i++)
		begin
			xfer(1'b1, OFS_FEATURE_TUNING, 32'((i / 4) << 6));
			xfer(1'b1, OFS_FIFO_SETUP, 32'(((i % 4) << 6) | ((i % 4) << 4) | 1));
			rd(OFS_FIFO_LEVEL, 33'(rxa[i]));
			lev(rxa[i], txa[i]);
		end
		xfer(1'b1, OFS_FIFO_SETUP, 32'h0);
		rd(OFS_FIFO_LEVEL, 33'h3C);
		chk(33'({fifo_enable, rx_ready_level}), 33'h0);
		xfer(1'b1, OFS_ENH_FEATURE, 32'h0);
		xfer(1'b1, OFS_FIFO_SETUP, 32'h01);
		rd(OFS_FIFO_LEVEL, 33'h3C);
		p = 7'($urandom_range(64, 2));
		q = 7'($urandom_range(64, 2));
		xfer(1'b1, OFS_RX_PROG_TRIG, 32'(p));
		xfer(1'b1, OFS_TX_PROG_TRIG, 32'(q));
		xfer(1'b1, OFS_FEATURE_TUNING, 32'hC0);
		rd(OFS_FIFO_LEVEL, 33'(p));
		rd(OFS_TX_PROG_TRIG, 33'(q));
		lev(p, q);
		// clock enable low must freeze the ready flags
		fifo_levels <= '{p, 7'h00};
		repeat (3) @(posedge pclk);
		chk(33'({rx_ready_level, tx_ready_level}), 33'h3);
		clk_en <= 1'b0;
		fifo_levels <= '{7'h00, 7'h7F};
		repeat (4) @(posedge pclk);
		chk(33'({rx_ready_level, tx_ready_level}), 33'h3);
		clk_en <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(33'({rx_ready_level, tx_ready_level}), 33'h0);
		$display("test triggers done");
		for (int i = 0; i < 64; i++)
		begin
			xfer(1'b1, OFS_LINE_FORMAT, 32'({1'($urandom), 6'(i)}));
			rd(OFS_LINE_FORMAT, 33'(pwdata));
		end
		xfer(1'b1, OFS_LINE_FORMAT, 32'h40);
		repeat (8) @(posedge pclk);
		chk(33'({low_run >= 8'h06, tx_serial_out}), 33'h2);
		xfer(1'b1, OFS_LINE_FORMAT, 32'h80);
		xfer(1'b1, OFS_DATA_LOW, 32'h34);
		xfer(1'b1, OFS_DATA_HIGH, 32'h12);
		rd(OFS_DATA_LOW, 33'h34);
		chk(33'(baud_divisor), 33'h1234);
		xfer(1'b1, OFS_LINE_FORMAT, 32'h0);
		rd(OFS_DATA_LOW, 33'h0);
		$display("test format done");
		for (int m = 0; m < 4; m++)
		begin
			xfer(1'b1, OFS_MODEM_LINE, 32'(m));
			repeat (2) @(posedge pclk);
			chk(33'({dtr_n, rts_n}), 33'({!m[0], !m[1]}));
		end
		xfer(1'b1, OFS_ENH_FEATURE, 32'h50);
		xfer(1'b1, OFS_MODEM_LINE, 32'h07);
		stop_req <= 1'b1;
		repeat (12) @(posedge pclk);
		chk(33'({dtr_n, rts_n}), 33'h2);
		xfer(1'b1, OFS_MODEM_LINE, 32'h03);
		repeat (12) @(posedge pclk);
		chk(33'({dtr_n, rts_n}), 33'h1);
		lag <= 4'h5;
		stop_req <= 1'b0;
		repeat (16) @(posedge pclk);
		chk(33'({dtr_n, rts_n}), 33'h0);
		$display("test modem done");
		close_out();
	end
endmodule : testbench
